// *** design/ttr_params.svh ***
// timing trigger recognizer: offsets, field positions, reset values, timing counts
// assumes: included by bare name, 200 MHz pclk
`ifndef TTR_PARAMS_SVH
`define TTR_PARAMS_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define TTR_OFF_CTRL      12'h000
`define TTR_OFF_STATUS    12'h004
`define TTR_OFF_PAT_CARE  12'h008
`define TTR_OFF_PAT_VAL   12'h00C
`define TTR_OFF_EDGE_RISE 12'h010
`define TTR_OFF_EDGE_FALL 12'h014
`define TTR_OFF_EDGE_AVL  12'h018
`define TTR_OFF_DURATION  12'h01C
`define TTR_OFF_SAMP_DIV  12'h020
`define TTR_OFF_TRIG_ADDR 12'h024
`define TTR_OFF_MEM_ADDR  12'h028
`define TTR_OFF_MEM_DATA  12'h02C
`define TTR_OFF_SLOT_BASE 12'h040

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define TTR_CTRL_RUN      0
`define TTR_CTRL_GLITCH   1
`define TTR_CTRL_POS_LO   2
`define TTR_CTRL_POS_HI   3
`define TTR_CTRL_DEFAULT  4
`define TTR_ST_SEARCH     0
`define TTR_ST_TRIG       1
`define TTR_ST_DONE       2
`define TTR_ST_SHOWN_LO   8
`define TTR_ST_BIGSP      16
`define TTR_SLOT_ON       4

// -----------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------
`define TTR_EDGE_AVL_RST  16'h0F0F
`define TTR_DIV_RST       16'h0001
`define TTR_CLK_NS        5
`define TTR_DUR_MIN_NS    20
`define TTR_DUR_MAX_NS    1000000
`define TTR_DUR_MIN_CYC   ((`TTR_DUR_MIN_NS + `TTR_CLK_NS - 1) / `TTR_CLK_NS)
`define TTR_DUR_MAX_CYC   (`TTR_DUR_MAX_NS / `TTR_CLK_NS)

`endif

// *** design/ttr_pkg.sv ***
// timing trigger recognizer: shared types
// assumes: nothing
package ttr_pkg;

  typedef enum logic [1:0] {TTR_IDLE, TTR_SEARCH, TTR_POST, TTR_DONE} ttr_cap_state_type;

  typedef enum logic [1:0] {TTR_POS_START, TTR_POS_CENTER, TTR_POS_END} ttr_pos_type;

endpackage

// *** design/ttr_term_eval.sv ***
// timing trigger recognizer: pattern (and) and edge (or) terms
// assumes: cur and prev are samples of consecutive sample periods on one clock
`timescale 1ns/10ps
module ttr_term_eval
  import ttr_pkg::*;
#(
  parameter int NCH = 16
) (
  // sample pair
  input  wire logic [NCH-1:0] cur,
  input  wire logic [NCH-1:0] prev,
  // term programming, bit 0 is the lowest channel
  input  wire logic [NCH-1:0] care,
  input  wire logic [NCH-1:0] val,
  input  wire logic [NCH-1:0] rise,
  input  wire logic [NCH-1:0] fall,
  // results
  output logic                pat_ok,
  output logic                edge_ok
);

  logic [NCH-1:0] rose;
  logic [NCH-1:0] fell;

  always_comb begin
    rose    = cur & ~prev;
    fell    = ~cur & prev;
    pat_ok  = ((cur ^ val) & care) == '0;
    edge_ok = |((rose & rise) | (fell & fall))
              || ((rise | fall) == '0);
  end

endmodule // ttr_term_eval

// *** design/ttr_slot_map.sv ***
// timing trigger recognizer: display trace slot mapper
// assumes: sample is stable per sample period, writes are one-cycle strobes
`timescale 1ns/10ps
module ttr_slot_map
  import ttr_pkg::*;
#(
  parameter int NCH   = 16,
  parameter int NSLOT = 16,
  parameter int CW    = $clog2(NCH),
  parameter int SW    = $clog2(NSLOT)
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // control
  input  wire logic                    wr_en,
  input  wire logic [SW-1:0]           wr_idx,
  input  wire logic [CW:0]             wr_data,
  input  wire logic                    restore,
  input  wire logic                    glitch,
  input  wire logic [NCH-1:0]          sample,
  // state and display
  output logic [NSLOT*(CW+1)-1:0]      slot_flat,
  output logic [SW:0]                  shown,
  output logic                         big_spacing,
  output logic [NSLOT-1:0]             trace
);

  logic [CW:0]      slot_r   [NSLOT];
  logic [CW:0]      slot_nxt [NSLOT];
  logic [SW:0]      shown_r, shown_nxt;
  logic             big_r, big_nxt;
  logic [NSLOT-1:0] trace_r, trace_nxt;
  logic [SW:0]      limit;

  // default assignment: slot i shows channel i, enabled only when i is below limit
  function automatic logic [CW:0] dflt(input int i, input logic [SW:0] lim);
    dflt = {(SW+1)'(i) < lim, CW'(i)};
  endfunction

  always_comb begin
    limit     = glitch ? (SW+1)'(NSLOT / 2) : (SW+1)'(NSLOT);
    shown_nxt = '0;
    for (int i = 0; i < NSLOT; i++) begin
      slot_nxt[i] = slot_r[i];
      if (restore) begin
        slot_nxt[i] = dflt(i, limit);
      end else if (wr_en && wr_idx == SW'(i)) begin
        slot_nxt[i] = wr_data;
      end
      if ((SW+1)'(i) >= limit) begin
        slot_nxt[i][CW] = 1'b0;
      end
      shown_nxt    = shown_nxt + (SW+1)'(slot_nxt[i][CW]);
      trace_nxt[i] = slot_r[i][CW] & sample[slot_r[i][CW-1:0]];
    end
    big_nxt = shown_nxt <= (SW+1)'(NSLOT / 2);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NSLOT; i++) begin
        slot_r[i] <= {1'b1, CW'(i)};
      end
      shown_r <= (SW+1)'(NSLOT);
      big_r   <= 1'b0;
      trace_r <= '0;
    end else begin
      slot_r  <= slot_nxt;
      shown_r <= shown_nxt;
      big_r   <= big_nxt;
      trace_r <= trace_nxt;
    end
  end

  generate
    for (genvar g = 0; g < NSLOT; g++) begin : g_flat
      assign slot_flat[g*(CW+1) +: CW+1] = slot_r[g];
    end
  endgenerate

  assign shown       = shown_r;
  assign big_spacing = big_r;
  assign trace       = trace_r;

endmodule // ttr_slot_map

// *** design/ttr_top.sv ***
// timing trigger recognizer: apb registers, sampling, trigger search, capture memory
// assumes: probe pins asynchronous to pclk, apb master on pclk
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "ttr_params.svh"
module ttr_top
  import ttr_pkg::*;
#(
  parameter int              NCH         = 16,
  parameter int              NSLOT       = 16,
  parameter int              DEPTH       = 1024,
  parameter int              DUR_MAX_CYC = `TTR_DUR_MAX_CYC,
  parameter logic [NCH-1:0]  EDGE_AVAIL  = `TTR_EDGE_AVL_RST
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // probe channels
  input  wire logic [NCH-1:0]    probe,
  // display and status
  output logic [NSLOT-1:0]       trace_out,
  output logic                   trace_big_spacing,
  output logic                   triggered,
  output logic                   capture_done
);

  localparam int CW = $clog2(NCH);
  localparam int SW = $clog2(NSLOT);
  localparam int AW = $clog2(DEPTH);
  localparam int DW = $clog2(DUR_MAX_CYC + 1);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [NCH-1:0]    sync1_r, sync2_r;
  logic [NCH-1:0]    cur_r, cur_nxt, prev_r, prev_nxt;
  logic [15:0]       divc_r, divc_nxt;
  logic              tick;
  logic              glitch_r, glitch_nxt;
  ttr_pos_type       pos_r, pos_nxt;
  logic [NCH-1:0]    care_r, care_nxt, val_r, val_nxt;
  logic [NCH-1:0]    rise_r, rise_nxt, fall_r, fall_nxt;
  logic [DW-1:0]     dur_r, dur_nxt, qual_r, qual_nxt;
  logic [15:0]       div_r, div_nxt;
  logic [AW-1:0]     rd_addr_r, rd_addr_nxt;
  logic [AW-1:0]     wptr_r, wptr_nxt, trig_addr_r, trig_addr_nxt;
  logic [AW-1:0]     post_r, post_nxt;
  ttr_cap_state_type st_r, st_nxt;
  logic              trig_r, trig_nxt, done_r, done_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  logic              pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [NCH-1:0]    mem [DEPTH];
  logic [NCH-1:0]    mem_q_r;
  logic              mem_we;

  // apb handshake, trigger term and display terms
  logic              setup, wr_go, run_go, restore_go, slot_wr;
  logic [SW-1:0]     slot_idx;
  logic              pat_ok, edge_ok, hit;
  logic [NCH-1:0]    chan_mask;
  logic [NSLOT*(CW+1)-1:0] slot_flat;
  logic [SW:0]       shown;
  logic [31:0]       dur_w;

  // is the address inside the trace slot window
  function automatic logic is_slot(input logic [11:0] a);
    is_slot = a >= `TTR_OFF_SLOT_BASE && a < `TTR_OFF_SLOT_BASE + 12'(4 * NSLOT);
  endfunction

  // -----------------------------------------------------------------
  // sub-blocks
  // -----------------------------------------------------------------
  ttr_term_eval #(.NCH(NCH)) u_terms (
    .cur     (cur_r),
    .prev    (prev_r),
    .care    (care_r),
    .val     (val_r),
    .rise    (rise_r),
    .fall    (fall_r),
    .pat_ok  (pat_ok),
    .edge_ok (edge_ok)
  );

  ttr_slot_map #(.NCH(NCH), .NSLOT(NSLOT)) u_slots (
    .pclk        (pclk),
    .presetn     (presetn),
    .wr_en       (slot_wr),
    .wr_idx      (slot_idx),
    .wr_data     (pwdata[CW:0]),
    .restore     (restore_go),
    .glitch      (glitch_r),
    .sample      (cur_r),
    .slot_flat   (slot_flat),
    .shown       (shown),
    .big_spacing (trace_big_spacing),
    .trace       (trace_out)
  );

  // -----------------------------------------------------------------
  // sampling and trigger search
  // -----------------------------------------------------------------
  always_comb begin
    setup      = psel && !penable;
    wr_go      = psel && penable && pready_r && pwrite && !pslverr_r;
    run_go     = wr_go && paddr == `TTR_OFF_CTRL && pwdata[`TTR_CTRL_RUN];
    restore_go = wr_go && paddr == `TTR_OFF_CTRL && pwdata[`TTR_CTRL_DEFAULT];
    slot_wr    = wr_go && is_slot(paddr);
    slot_idx   = SW'((paddr - `TTR_OFF_SLOT_BASE) >> 2);
    // glitch mode keeps only the lower half of the channels
    chan_mask  = glitch_r ? {{(NCH-NCH/2){1'b0}}, {(NCH/2){1'b1}}} : {NCH{1'b1}};
    // a divider lowered below the running count must not stall for a full wrap
    tick       = divc_r >= div_r;
    divc_nxt   = tick ? 16'h0000 : divc_r + 16'h0001;
    cur_nxt    = tick ? (sync2_r & chan_mask) : cur_r;
    prev_nxt   = tick ? cur_r : prev_r;
    qual_nxt   = !pat_ok ? '0 : (qual_r == dur_r) ? qual_r : qual_r + DW'(1);
    // condition must have held for the valid duration, edge in this period
    hit        = pat_ok && edge_ok && qual_r + DW'(1) >= dur_r;
    st_nxt        = st_r;
    wptr_nxt      = wptr_r;
    post_nxt      = post_r;
    trig_addr_nxt = trig_addr_r;
    trig_nxt      = trig_r;
    done_nxt      = done_r;
    mem_we        = 1'b0;
    if (tick && (st_r == TTR_SEARCH || st_r == TTR_POST)) begin
      mem_we   = 1'b1;
      wptr_nxt = wptr_r + AW'(1);
    end
    case (st_r)
      TTR_SEARCH: begin
        if (hit) begin
          trig_nxt      = 1'b1;
          trig_addr_nxt = wptr_r;
          case (pos_r)
            TTR_POS_START:  post_nxt = AW'(DEPTH - 1);
            TTR_POS_CENTER: post_nxt = AW'(DEPTH / 2);
            default:        post_nxt = '0;
          endcase
          st_nxt = TTR_POST;
        end
      end
      TTR_POST: begin
        if (post_r == '0) begin
          st_nxt   = TTR_DONE;
          done_nxt = 1'b1;
        end else if (tick) begin
          post_nxt = post_r - AW'(1);
        end
      end
      default: begin
      end
    endcase
    if (run_go) begin
      st_nxt   = TTR_SEARCH;
      wptr_nxt = '0;
      trig_nxt = 1'b0;
      done_nxt = 1'b0;
      qual_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r     <= '0;
      sync2_r     <= '0;
      cur_r       <= '0;
      prev_r      <= '0;
      divc_r      <= '0;
      qual_r      <= '0;
      st_r        <= TTR_IDLE;
      wptr_r      <= '0;
      post_r      <= '0;
      trig_addr_r <= '0;
      trig_r      <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      sync1_r     <= probe;
      sync2_r     <= sync1_r;
      cur_r       <= cur_nxt;
      prev_r      <= prev_nxt;
      divc_r      <= divc_nxt;
      qual_r      <= qual_nxt;
      st_r        <= st_nxt;
      wptr_r      <= wptr_nxt;
      post_r      <= post_nxt;
      trig_addr_r <= trig_addr_nxt;
      trig_r      <= trig_nxt;
      done_r      <= done_nxt;
    end
  end

  // capture memory, written once per sample period
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[wptr_r] <= sync2_r & chan_mask;
    end
    mem_q_r <= mem[rd_addr_r];
  end

  // -----------------------------------------------------------------
  // apb registers
  // -----------------------------------------------------------------
  always_comb begin
    glitch_nxt  = glitch_r;
    pos_nxt     = pos_r;
    care_nxt    = care_r;
    val_nxt     = val_r;
    rise_nxt    = rise_r;
    fall_nxt    = fall_r;
    dur_nxt     = dur_r;
    div_nxt     = div_r;
    rd_addr_nxt = rd_addr_r;
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt  = setup;
    dur_w       = pwdata;
    if (pwdata < 32'(`TTR_DUR_MIN_CYC)) begin
      dur_w = 32'(`TTR_DUR_MIN_CYC);
    end else if (pwdata > 32'(DUR_MAX_CYC)) begin
      dur_w = 32'(DUR_MAX_CYC);
    end
    if (paddr == `TTR_OFF_CTRL) begin
      prdata_nxt = {28'h000_0000, pos_r, glitch_r, 1'b0};
      if (wr_go) begin
        glitch_nxt = pwdata[`TTR_CTRL_GLITCH];
        pos_nxt    = ttr_pos_type'(pwdata[`TTR_CTRL_POS_HI:`TTR_CTRL_POS_LO]);
      end
    end else if (paddr == `TTR_OFF_STATUS) begin
      prdata_nxt[`TTR_ST_SEARCH]                    = st_r == TTR_SEARCH;
      prdata_nxt[`TTR_ST_TRIG]                      = trig_r;
      prdata_nxt[`TTR_ST_DONE]                      = done_r;
      prdata_nxt[`TTR_ST_SHOWN_LO +: SW+1]          = shown;
      prdata_nxt[`TTR_ST_BIGSP]                     = trace_big_spacing;
    end else if (paddr == `TTR_OFF_PAT_CARE) begin
      prdata_nxt[NCH-1:0] = care_r;
      care_nxt = wr_go ? pwdata[NCH-1:0] : care_r;
    end else if (paddr == `TTR_OFF_PAT_VAL) begin
      prdata_nxt[NCH-1:0] = val_r;
      val_nxt = wr_go ? pwdata[NCH-1:0] : val_r;
    end else if (paddr == `TTR_OFF_EDGE_RISE) begin
      prdata_nxt[NCH-1:0] = rise_r;
      rise_nxt = wr_go ? pwdata[NCH-1:0] & EDGE_AVAIL : rise_r;
    end else if (paddr == `TTR_OFF_EDGE_FALL) begin
      prdata_nxt[NCH-1:0] = fall_r;
      fall_nxt = wr_go ? pwdata[NCH-1:0] & EDGE_AVAIL : fall_r;
    end else if (paddr == `TTR_OFF_EDGE_AVL) begin
      prdata_nxt[NCH-1:0] = EDGE_AVAIL;
    end else if (paddr == `TTR_OFF_DURATION) begin
      prdata_nxt[DW-1:0] = dur_r;
      dur_nxt = wr_go ? dur_w[DW-1:0] : dur_r;
    end else if (paddr == `TTR_OFF_SAMP_DIV) begin
      prdata_nxt[15:0] = div_r;
      div_nxt = wr_go ? pwdata[15:0] : div_r;
    end else if (paddr == `TTR_OFF_TRIG_ADDR) begin
      prdata_nxt[AW-1:0] = trig_addr_r;
    end else if (paddr == `TTR_OFF_MEM_ADDR) begin
      prdata_nxt[AW-1:0] = rd_addr_r;
      rd_addr_nxt = wr_go ? pwdata[AW-1:0] : rd_addr_r;
    end else if (paddr == `TTR_OFF_MEM_DATA) begin
      prdata_nxt[NCH-1:0] = mem_q_r;
    end else if (is_slot(paddr)) begin
      prdata_nxt[CW:0] = slot_flat[32'(slot_idx) * (CW+1) +: CW+1];
    end else begin
      pslverr_nxt = setup;
    end
    // error response stands only for the one access cycle, like pready
    if (!setup) begin
      prdata_nxt  = prdata_r;
      pslverr_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glitch_r  <= 1'b0;
      pos_r     <= TTR_POS_CENTER;
      care_r    <= '0;
      val_r     <= '0;
      rise_r    <= '0;
      fall_r    <= '0;
      dur_r     <= DW'(`TTR_DUR_MIN_CYC);
      div_r     <= `TTR_DIV_RST;
      rd_addr_r <= '0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      glitch_r  <= glitch_nxt;
      pos_r     <= pos_nxt;
      care_r    <= care_nxt;
      val_r     <= val_nxt;
      rise_r    <= rise_nxt;
      fall_r    <= fall_nxt;
      dur_r     <= dur_nxt;
      div_r     <= div_nxt;
      rd_addr_r <= rd_addr_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign triggered    = trig_r;
  assign capture_done = done_r;

endmodule // ttr_top

// *** bench/ttr_probe_model.sv ***
// probed logic signals of the system under test
// assumes: the bench calls drive from one process at a time
`timescale 1ns/10ps
module ttr_probe_model #(
  parameter int NCH = 16
) (
  input  wire logic           pclk,
  output logic [NCH-1:0]      probe
);
  initial probe = '0;

  // hold a level for n cycles; short n gives fast activity, long n slow
  task automatic drive(input logic [NCH-1:0] v, input int n);
    @(posedge pclk);
    probe <= v;
    repeat (n) @(posedge pclk);
  endtask
endmodule // ttr_probe_model

// *** bench/ttr_top_properties.sv ***
// port assertions for ttr_top, bound into every instance
// assumes: zero wait state apb slave, run pulse in ctrl bit 0
`timescale 1ns/10ps
module ttr_top_properties #(
  parameter int NCH   = 16,
  parameter int NSLOT = 16
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [NCH-1:0]   probe,
  input wire logic [NSLOT-1:0] trace_out,
  input wire logic             trace_big_spacing,
  input wire logic             triggered,
  input wire logic             capture_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic run_w;
  assign run_w = psel && pwrite && paddr == 12'h000 && pwdata[0];

  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_clean_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response malformed");
  err_unmapped_a: assert property (psel && !penable && paddr == 12'h030 |=> pslverr)
    else $error("unmapped access not refused");
  status_no_err_a: assert property (psel && !penable && paddr == 12'h004 |=> !pslverr)
    else $error("status access refused");
  done_needs_trig_a: assert property (capture_done |-> triggered)
    else $error("done without trigger");
  trig_holds_a: assert property (triggered && !run_w && !$past(run_w) |=> triggered)
    else $error("triggered dropped without run");
  done_holds_a: assert property (capture_done && !run_w && !$past(run_w) |=> capture_done)
    else $error("done dropped without run");

  cover property ($rose(triggered));
  cover property ($rose(capture_done));
  cover property (pslverr);
  cover property ($rose(trace_big_spacing));
endmodule // ttr_top_properties

bind ttr_top ttr_top_properties #(.NCH(NCH), .NSLOT(NSLOT)) i_ttr_top_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .probe(probe), .trace_out(trace_out), .trace_big_spacing(trace_big_spacing),
  .triggered(triggered), .capture_done(capture_done)
);

// *** bench/testbench.sv ***
// self-checking bench for ttr_top with apb tasks and a probe model
// assumes: zero wait state slave, DUR_MAX_CYC set to 64 here
`timescale 1ns/10ps
`include "ttr_params.svh"
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] probe;
  logic [15:0] trace_out;
  logic        trace_big_spacing;
  logic        triggered;
  logic        capture_done;
  logic [32:0] exq[$];
  int          error_cnt;
  int          check_count;
  int          n;
  int          post;
  logic [31:0] seed;
  logic [31:0] v;
  logic [15:0] s;

  ttr_top #(.DUR_MAX_CYC(64)) i_ttr_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .probe(probe), .trace_out(trace_out), .trace_big_spacing(trace_big_spacing),
    .triggered(triggered), .capture_done(capture_done));
  ttr_probe_model i_ttr_probe_model (.pclk(pclk), .probe(probe));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    exq.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic pr(input logic [15:0] pv, input int k);
    i_ttr_probe_model.drive(pv, k);
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // read results leave the queue in order as the slave answers
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exq.size() == 0) error_cnt++;
      else chk({pslverr, prdata}, exq.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    seed = 32'd31;
    error_cnt = 0;
    check_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TTR_OFF_PAT_CARE, 32'h0000_0000);
    rd(`TTR_OFF_EDGE_AVL, 32'h0000_0F0F);
    rd(`TTR_OFF_STATUS, 32'h0000_1000);
    for (int i = 0; i < 16; i++) rd(`TTR_OFF_SLOT_BASE + 12'(4 * i), 32'h10 | i);
    rd(12'h030, 32'h0000_0000, 1'b1);
    wr(`TTR_OFF_EDGE_RISE, 32'h0000_FFFF);
    rd(`TTR_OFF_EDGE_RISE, 32'h0000_0F0F);
    repeat (4) begin
      v = rnd() & 32'h0000_FFFF;
      wr(`TTR_OFF_PAT_VAL, v);
      rd(`TTR_OFF_PAT_VAL, v);
    end
    wr(`TTR_OFF_DURATION, 32'h0000_0002);
    rd(`TTR_OFF_DURATION, 32'h0000_0004);
    wr(`TTR_OFF_DURATION, 32'h0000_03E8);
    rd(`TTR_OFF_DURATION, 32'h0000_0040);
    $display("registers done");
    wr(`TTR_OFF_CTRL, 32'h0000_0006);
    rd(`TTR_OFF_STATUS, 32'h0001_0800);
    wr(`TTR_OFF_SLOT_BASE + 12'h024, 32'h0000_0019);
    rd(`TTR_OFF_SLOT_BASE + 12'h024, 32'h0000_0009);
    wr(`TTR_OFF_CTRL, 32'h0000_0004);
    wr(`TTR_OFF_CTRL, 32'h0000_0014);
    rd(`TTR_OFF_SLOT_BASE + 12'h024, 32'h0000_0019);
    wr(`TTR_OFF_SLOT_BASE, 32'h0000_0000);
    wr(`TTR_OFF_SLOT_BASE + 12'h004, 32'h0000_0015);
    pr(16'h0020, 10);
    chk(trace_out[1:0], 2'b10);
    for (int i = 9; i < 16; i++) wr(`TTR_OFF_SLOT_BASE + 12'(4 * i), 32'h0000_0000);
    rd(`TTR_OFF_STATUS, 32'h0001_0800);
    chk(trace_big_spacing, 1'b1);
    wr(`TTR_OFF_CTRL, 32'h0000_0014);
    rd(`TTR_OFF_SLOT_BASE + 12'h004, 32'h0000_0011);
    $display("display slots done");
    wr(`TTR_OFF_EDGE_RISE, 32'h0000_0000);
    wr(`TTR_OFF_DURATION, 32'h0000_0004);
    wr(`TTR_OFF_PAT_CARE, 32'h0000_0003);
    wr(`TTR_OFF_PAT_VAL, 32'h0000_0001);
    pr(16'h0000, 4);
    wr(`TTR_OFF_CTRL, 32'h0000_0009);
    pr(16'h0003, 20);
    chk(triggered, 1'b0);
    pr(16'h0002, 20);
    chk(triggered, 1'b0);
    pr(16'h0001, 20);
    chk(triggered, 1'b1);
    chk(capture_done, 1'b1);
    wr(`TTR_OFF_DURATION, 32'h0000_001E);
    pr(16'h0000, 4);
    wr(`TTR_OFF_CTRL, 32'h0000_0009);
    pr(16'h0001, 8);
    pr(16'h0000, 10);
    chk(triggered, 1'b0);
    pr(16'h0001, 50);
    chk(triggered, 1'b1);
    $display("pattern done");
    wr(`TTR_OFF_DURATION, 32'h0000_0004);
    wr(`TTR_OFF_PAT_CARE, 32'h0000_0000);
    for (int m = 1; m < 4; m++) begin
      s = (m == 2) ? 16'h0000 : 16'h0008;
      wr(`TTR_OFF_EDGE_RISE, m[0] ? 32'h0000_0208 : 32'h0000_0000);
      wr(`TTR_OFF_EDGE_FALL, m[1] ? 32'h0000_0208 : 32'h0000_0000);
      pr(s, 4);
      wr(`TTR_OFF_CTRL, 32'h0000_0009);
      pr(s, 10);
      chk(triggered, 1'b0);
      pr(s ^ 16'h0008, 10);
      chk(triggered, m == 3);
      pr(s, 10);
      chk(triggered, 1'b1);
    end
    $display("edges done");
    wr(`TTR_OFF_EDGE_RISE, 32'h0000_0000);
    wr(`TTR_OFF_EDGE_FALL, 32'h0000_0000);
    for (int p = 0; p < 3; p++) begin
      wr(`TTR_OFF_CTRL, (32'(p) << 2) | 32'h0000_0001);
      @(posedge pclk);
      n = 0;
      while (capture_done !== 1'b1 && n < 3000) begin
        @(posedge pclk);
        n++;
      end
      post = (p == 0) ? 1023 : (p == 1) ? 512 : 0;
      chk(n >= 2 * post && n <= 2 * post + 20, 1'b1);
    end
    $display("positions done");
    wr(`TTR_OFF_MEM_ADDR, 32'h0000_0000);
    rd(`TTR_OFF_MEM_DATA, 32'h0000_0008);
    pr(16'h0108, 6);
    wr(`TTR_OFF_CTRL, 32'h0000_000B);
    pr(16'h0108, 10);
    wr(`TTR_OFF_MEM_ADDR, 32'h0000_0001);
    rd(`TTR_OFF_MEM_DATA, 32'h0000_0008);
    $display("memory done");
    finish_test();
  end
endmodule // testbench
